// file: design/dmt_map.vh
`ifndef DMT_MAP_VH
`define DMT_MAP_VH

// Register indexes (byte address = 4 * index)
`define DMT_IDX_CONTROL      16'h7fa5
`define DMT_IDX_FIRST_LOW    16'h7fa6
`define DMT_IDX_FIRST_HIGH   16'h7fa7
`define DMT_IDX_SECOND_LOW   16'h7fa8
`define DMT_IDX_SECOND_HIGH  16'h7fa9
`define DMT_IDX_CLOCK_SET    16'h7fb7

// Control register fields
`define DMT_BIT_FIRST_IE     0
`define DMT_BIT_FIRST_FLAG   1
`define DMT_BIT_FIRST_CKSEL  2
`define DMT_BIT_FIRST_RUN    3
`define DMT_BIT_SECOND_IE    4
`define DMT_BIT_SECOND_FLAG  5
`define DMT_BIT_SECOND_CKSEL 6
`define DMT_BIT_SECOND_RUN   7

// Clock setting register fields
`define DMT_PR_PERIOD_MSB    7
`define DMT_PR_PERIOD_LSB    4
`define DMT_PR_CLOCK_MSB     3
`define DMT_PR_CLOCK_LSB     2
`define DMT_CLK_SET_MASK     8'hfd

// Prescaler clock choices
`define DMT_PCK_SYSTEM       2'h0
`define DMT_PCK_INHIBIT      2'h1
`define DMT_PCK_OSC_FIRST    2'h2
`define DMT_PCK_OSC_SECOND   2'h3

// Reset values
`define DMT_RST_CONTROL      8'h00
`define DMT_RST_MATCH        8'h00
`define DMT_RST_CLOCK_SET    8'h00

`endif

// file: design/dmt_timer.v
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// RL1: Two independent 16-bit timers with own run, clock, match and interrupt.
// RL2: Period is ({high,low}+1) count clocks; toggle output period is twice that.
// RL3: Each timer requests an interrupt once per period while enabled.
// RL4: First timer counts while control bit 3 is one.
// RL5: Second timer counts while control bit 7 is one.
// RL6: Control bit 2 picks first timer clock: system or prescaler match.
// RL7: Control bit 6 picks second timer clock: system or prescaler match.
// RL8: Timer match compares against its internal match buffer only.
// RL9: Counter clears when stopped and on its match.
// RL10: Stopped timer's match buffer follows its match-data registers.
// RL11: Running timer reloads its match buffer only on match.
// RL12: Software updates prescaled timer match data at most once per period.
// RL13: Shared 4-bit prescaler runs when either clock-select bit is one.
// RL14: Clock-setting bits 3:2 pick prescaler clock: system, none, oscillators.
// RL15: Prescaler pulses on match, clears on match and when stopped.
// RL16: Toggle output high while stopped, inverts on each match while running.
// RL17: Match-data pair accessible as single bytes or one 16-bit access.
// RL18: Flag sets when running timer count becomes zero; software clears it.
// RL19: Interrupt request asserted when flag and enable both set.
// RL20: Software changes clock-select bit only while the timer is stopped.
// RL21: Prescaler period is (bits 7:4 value + 1) prescaler clocks.
// RL22: All counting on system clock; selected pulses act as count enables.
`include "dmt_map.vh"

module dmt_timer (
  // Clock and reset
  input  wire        CLOCK,
  input  wire        RESET,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [17:0] PADDR,
  input  wire [31:0] PWDATA,
  input  wire [3:0]  PSTRB,
  output wire        PREADY,
  output wire        PSLVERR,
  output reg  [31:0] PRDATA,
  // Oscillator pins
  input  wire        FIRST_OSCILLATOR,
  input  wire        SECOND_OSCILLATOR,
  // Timer outputs
  output wire        FIRST_TOGGLE_OUT,
  output wire        SECOND_TOGGLE_OUT,
  output wire        FIRST_IRQ,
  output wire        SECOND_IRQ
);

  reg  [7:0]  pair_control;
  reg  [7:0]  match_low [0:1];
  reg  [7:0]  match_high [0:1];
  reg  [7:0]  prescaler_clock_setting;
  reg  [2:0]  osc_first_sync;
  reg  [2:0]  osc_second_sync;
  reg         osc_first_state;
  reg         osc_second_state;
  reg  [3:0]  prescaler_count;
  reg  [15:0] count [0:1];
  reg  [15:0] match_buffer [0:1];
  reg  [1:0]  toggle_out;
  reg  [1:0]  set_flag;
  wire [1:0]  run_bit;
  wire [1:0]  clock_select;
  wire [1:0]  irq_enable;
  wire [1:0]  match_flag;
  wire [1:0]  timer_match;
  wire [1:0]  timer_tick;
  wire        prescaler_run;
  wire        osc_first_rise;
  wire        osc_second_rise;
  reg         prescaler_tick;
  wire        prescaler_match;
  wire [15:0] word_index;
  wire        apb_write;
  wire        addr_ok;
  wire        sel_control;
  wire        sel_clock;
  wire [1:0]  sel_low;
  wire [1:0]  sel_high;
  wire [1:0]  sel_pair16;

  assign run_bit      = {pair_control[`DMT_BIT_SECOND_RUN], pair_control[`DMT_BIT_FIRST_RUN]};
  assign clock_select = {pair_control[`DMT_BIT_SECOND_CKSEL],
                         pair_control[`DMT_BIT_FIRST_CKSEL]};
  assign irq_enable   = {pair_control[`DMT_BIT_SECOND_IE], pair_control[`DMT_BIT_FIRST_IE]};
  assign match_flag   = {pair_control[`DMT_BIT_SECOND_FLAG],
                         pair_control[`DMT_BIT_FIRST_FLAG]};

  // Bus decode: word index is the address divided by four
  assign PREADY      = 1'b1;
  assign word_index  = PADDR[17:2];
  assign apb_write   = PSEL & PENABLE & PWRITE;
  assign sel_control = (word_index == `DMT_IDX_CONTROL);
  assign sel_clock   = (word_index == `DMT_IDX_CLOCK_SET);
  assign sel_low     = {(word_index == `DMT_IDX_SECOND_LOW), (word_index == `DMT_IDX_FIRST_LOW)};
  assign sel_high    = {(word_index == `DMT_IDX_SECOND_HIGH),
                        (word_index == `DMT_IDX_FIRST_HIGH)};
  // A 16-bit access at the low index with both low strobes writes the pair at once
  assign sel_pair16  = sel_low & {2{PSTRB[1]}};
  assign addr_ok     = sel_control | sel_clock | (|sel_low) | (|sel_high);
  assign PSLVERR     = PSEL & PENABLE & ~addr_ok;

  // Control register; hardware set beats software clear on the flags
  always @(posedge CLOCK) begin
    if (RESET) begin
      pair_control <= `DMT_RST_CONTROL;
    end else begin
      if (apb_write && sel_control && PSTRB[0]) begin
        pair_control <= PWDATA[7:0];
      end
      if (set_flag[0]) begin
        pair_control[`DMT_BIT_FIRST_FLAG] <= 1'b1; // RL18
      end
      if (set_flag[1]) begin
        pair_control[`DMT_BIT_SECOND_FLAG] <= 1'b1; // RL18
      end
    end
  end

  // Clock setting register; bit 1 does not exist
  always @(posedge CLOCK) begin
    if (RESET) begin
      prescaler_clock_setting <= `DMT_RST_CLOCK_SET;
    end else if (apb_write && sel_clock && PSTRB[0]) begin
      prescaler_clock_setting <= PWDATA[7:0] & `DMT_CLK_SET_MASK;
    end
  end

  // Read mux
  always @(posedge CLOCK) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= 32'h0000_0000;
      if (sel_control) begin
        PRDATA[7:0] <= pair_control;
      end
      if (sel_clock) begin
        PRDATA[7:0] <= prescaler_clock_setting;
      end
      if (sel_low[0]) begin
        PRDATA[15:0] <= {match_high[0], match_low[0]}; // RL17
      end
      if (sel_low[1]) begin
        PRDATA[15:0] <= {match_high[1], match_low[1]}; // RL17
      end
      if (sel_high[0]) begin
        PRDATA[7:0] <= match_high[0];
      end
      if (sel_high[1]) begin
        PRDATA[7:0] <= match_high[1];
      end
    end
  end

  // Oscillator pins: three stages, a rising change counts when stages two and three agree
  always @(posedge CLOCK) begin
    if (RESET) begin
      osc_first_sync   <= 3'h0;
      osc_second_sync  <= 3'h0;
      osc_first_state  <= 1'b0;
      osc_second_state <= 1'b0;
    end else begin
      osc_first_sync  <= {osc_first_sync[1:0], FIRST_OSCILLATOR};
      osc_second_sync <= {osc_second_sync[1:0], SECOND_OSCILLATOR};
      if (osc_first_sync[1] == osc_first_sync[2]) begin
        osc_first_state <= osc_first_sync[2];
      end
      if (osc_second_sync[1] == osc_second_sync[2]) begin
        osc_second_state <= osc_second_sync[2];
      end
    end
  end

  assign osc_first_rise  = (osc_first_sync[1] == osc_first_sync[2]) &
                           osc_first_sync[2] & ~osc_first_state;
  assign osc_second_rise = (osc_second_sync[1] == osc_second_sync[2]) &
                           osc_second_sync[2] & ~osc_second_state;

  // Prescaler count enable
  always @* begin
    case (prescaler_clock_setting[`DMT_PR_CLOCK_MSB:`DMT_PR_CLOCK_LSB]) // RL14
      `DMT_PCK_SYSTEM:     prescaler_tick = 1'b1;
      `DMT_PCK_INHIBIT:    prescaler_tick = 1'b0;
      `DMT_PCK_OSC_FIRST:  prescaler_tick = osc_first_rise;
      `DMT_PCK_OSC_SECOND: prescaler_tick = osc_second_rise;
      default:             prescaler_tick = 1'b0;
    endcase
  end

  assign prescaler_run   = |clock_select; // RL13
  assign prescaler_match = prescaler_run & prescaler_tick &
    (prescaler_count == prescaler_clock_setting[`DMT_PR_PERIOD_MSB:`DMT_PR_PERIOD_LSB]); // RL21

  always @(posedge CLOCK) begin
    if (RESET) begin
      prescaler_count <= 4'h0;
    end else if (!prescaler_run || prescaler_match) begin
      prescaler_count <= 4'h0; // RL15
    end else if (prescaler_tick) begin
      prescaler_count <= prescaler_count + 4'h1; // RL22
    end
  end

  // Both timers and their match-data pairs
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : g_timer // RL1
      // Run bits 3 and 7, clock selects 2 and 6
      assign timer_tick[t]  = run_bit[t] &
                              (clock_select[t] ? prescaler_match : 1'b1); // RL4 RL5 RL6 RL7 RL22
      assign timer_match[t] = timer_tick[t] & (count[t] == match_buffer[t]); // RL8 RL2

      always @(posedge CLOCK) begin
        if (RESET) begin
          match_low[t]  <= `DMT_RST_MATCH;
          match_high[t] <= `DMT_RST_MATCH;
        end else if (apb_write) begin
          if (sel_low[t] && PSTRB[0]) begin
            match_low[t] <= PWDATA[7:0]; // RL17
          end
          if (sel_pair16[t]) begin
            match_high[t] <= PWDATA[15:8]; // RL17
          end else if (sel_high[t] && PSTRB[0]) begin
            match_high[t] <= PWDATA[7:0]; // RL17
          end
        end
      end

      always @(posedge CLOCK) begin
        if (RESET) begin
          count[t]        <= 16'h0000;
          match_buffer[t] <= 16'h0000;
          toggle_out[t]   <= 1'b1;
          set_flag[t]     <= 1'b0;
        end else begin
          set_flag[t] <= timer_match[t]; // RL18 RL3
          if (!run_bit[t]) begin
            count[t]        <= 16'h0000; // RL9
            match_buffer[t] <= {match_high[t], match_low[t]}; // RL10
            toggle_out[t]   <= 1'b1; // RL16
          end else if (timer_match[t]) begin
            count[t]        <= 16'h0000; // RL9
            match_buffer[t] <= {match_high[t], match_low[t]}; // RL11 RL12
            toggle_out[t]   <= ~toggle_out[t]; // RL16 RL2
          end else if (timer_tick[t]) begin
            count[t] <= count[t] + 16'h0001;
          end
        end
      end
    end
  endgenerate

  assign FIRST_TOGGLE_OUT  = toggle_out[0];
  assign SECOND_TOGGLE_OUT = toggle_out[1];
  assign FIRST_IRQ         = match_flag[0] & irq_enable[0]; // RL19 RL3
  assign SECOND_IRQ        = match_flag[1] & irq_enable[1]; // RL19 RL3

endmodule // dmt_timer

// file: tb/dmt_timer_checker.sv
`timescale 1ns/1ps
module dmt_timer_checker (
  // Clock and reset
  input wire        CLOCK,
  input wire        RESET,
  // APB
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [17:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0]  PSTRB,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire [31:0] PRDATA,
  // Timer outputs
  input wire        FIRST_TOGGLE_OUT,
  input wire        SECOND_TOGGLE_OUT,
  input wire        FIRST_IRQ,
  input wire        SECOND_IRQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // Byte write to the control register
  sequence ctl_wr;
    PSEL && PENABLE && PWRITE && PSTRB[0] && PADDR[17:2] == 16'h7fa5;
  endsequence
  // Access phase at an unmapped index
  sequence bad_acc;
    PSEL && PENABLE && PADDR[17:2] == 16'h0000;
  endsequence
  ready_in_access_a: assert property (PSEL && PENABLE |-> PREADY)
    else $error("ready low in access phase");
  unmapped_error_a: assert property (bad_acc |-> PSLVERR)
    else $error("no error on unmapped access");
  unmapped_zero_a: assert property (bad_acc ##0 !PWRITE |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
    else $error("read data moved outside read setup");
  first_stop_high_a: assert property (ctl_wr ##0 !PWDATA[3] |-> ##2 FIRST_TOGGLE_OUT)
    else $error("first toggle not high when stopped");
  second_stop_high_a: assert property (ctl_wr ##0 !PWDATA[7] |-> ##2 SECOND_TOGGLE_OUT)
    else $error("second toggle not high when stopped");
  first_irq_off_a: assert property (ctl_wr ##0 !PWDATA[0] |=> !FIRST_IRQ)
    else $error("first request with enable low");
  second_irq_off_a: assert property (ctl_wr ##0 !PWDATA[4] |=> !SECOND_IRQ)
    else $error("second request with enable low");
endmodule // dmt_timer_checker

bind dmt_timer dmt_timer_checker chk_u (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .FIRST_TOGGLE_OUT(FIRST_TOGGLE_OUT),
  .SECOND_TOGGLE_OUT(SECOND_TOGGLE_OUT), .FIRST_IRQ(FIRST_IRQ), .SECOND_IRQ(SECOND_IRQ));

// file: tb/dual_match_timer_prescaled_tb.sv
`timescale 1ns/1ps
module dual_match_timer_prescaled_tb;
  logic        CLOCK = 1'b0;
  logic        RESET = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [17:0] PADDR = 18'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0]  PSTRB = 4'h0;
  logic        FIRST_OSCILLATOR = 1'b0;
  logic        SECOND_OSCILLATOR = 1'b0;
  logic [2:0]  osc_div = 3'h0;
  wire         PREADY, PSLVERR, FIRST_TOGGLE_OUT, SECOND_TOGGLE_OUT, FIRST_IRQ, SECOND_IRQ;
  wire  [31:0] PRDATA;
  logic [31:0] r;
  logic        e;
  int          failures = 0;
  int          n_checks = 0;
  int          n;
  always #5 CLOCK = ~CLOCK;
  // Oscillators with periods of 4 and 8 clocks
  always @(posedge CLOCK) begin
    osc_div <= osc_div + 3'h1;
    FIRST_OSCILLATOR <= osc_div[1];
    SECOND_OSCILLATOR <= osc_div[2];
  end
  dmt_timer dut_u (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PRDATA(PRDATA), .FIRST_OSCILLATOR(FIRST_OSCILLATOR),
    .SECOND_OSCILLATOR(SECOND_OSCILLATOR), .FIRST_TOGGLE_OUT(FIRST_TOGGLE_OUT),
    .SECOND_TOGGLE_OUT(SECOND_TOGGLE_OUT), .FIRST_IRQ(FIRST_IRQ), .SECOND_IRQ(SECOND_IRQ));
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is seen
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {idx, 2'b00};
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    i = 0;
    do begin
      @(posedge CLOCK);
      i++;
    end while (PREADY !== 1'b1 && i < 20);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (i >= 20) begin
      failures++;
      give_verdict();
    end
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, 4'h0);
    chk(r, exp);
  endtask
  // Clocks between two successive toggle changes
  task automatic meas(input logic sec, output int cnt);
    logic last;
    for (int p = 0; p < 2; p++) begin
      last = sec ? SECOND_TOGGLE_OUT : FIRST_TOGGLE_OUT;
      cnt = 0;
      do begin
        @(posedge CLOCK);
        #1;
        cnt++;
      end while ((sec ? SECOND_TOGGLE_OUT : FIRST_TOGGLE_OUT) === last && cnt < 200);
    end
  endtask
  task automatic test_regs();
    logic [15:0] ids [6] = '{16'h7fa5, 16'h7fa6, 16'h7fa7, 16'h7fa8, 16'h7fa9, 16'h7fb7};
    foreach (ids[j]) rdc(ids[j], 32'h0);
    apb(1'b0, 16'h0000, 32'h0, 4'h0);
    chk(e, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, 16'h7fa6, 32'h1234, 4'h3);
    rdc(16'h7fa6, 32'h1234);
    rdc(16'h7fa7, 32'h12);
    apb(1'b1, 16'h7fb7, 32'hff, 4'h1);
    rdc(16'h7fb7, 32'hfd);
    $display("Registers test done");
  endtask
  task automatic test_first();
    int k;
    apb(1'b1, 16'h7fa6, 32'h0003, 4'h3);
    apb(1'b1, 16'h7fa5, 32'h09, 4'h1);
    meas(1'b0, n);
    chk(n, 4);
    for (k = 0; k < 20 && FIRST_IRQ !== 1'b1; k++) @(posedge CLOCK);
    chk(FIRST_IRQ, 1);
    rdc(16'h7fa5, 32'h0b);
    apb(1'b1, 16'h7fa5, 32'h08, 4'h1);
    @(posedge CLOCK);
    chk(FIRST_IRQ, 0);
    apb(1'b1, 16'h7fa6, 32'h0005, 4'h3);
    meas(1'b0, n);
    chk(n, 6);
    apb(1'b1, 16'h7fa5, 32'h00, 4'h1);
    repeat (3) @(posedge CLOCK);
    chk(FIRST_TOGGLE_OUT, 1);
    $display("First timer test done");
  endtask
  task automatic test_second();
    logic [7:0]  modes [3] = '{8'h20, 8'h28, 8'h2c};
    int          exp [3] = '{6, 24, 48};
    logic        last;
    int          k;
    apb(1'b1, 16'h7fa8, 32'h0001, 4'h3);
    apb(1'b1, 16'h7fa5, 32'h40, 4'h1);
    apb(1'b1, 16'h7fa5, 32'hc0, 4'h1);
    foreach (modes[j]) begin
      apb(1'b1, 16'h7fb7, {24'h0, modes[j]}, 4'h1);
      meas(1'b1, n);
      chk(n, exp[j]);
    end
    apb(1'b1, 16'h7fb7, 32'h20, 4'h1);
    apb(1'b1, 16'h7fa8, 32'h0003, 4'h3);
    meas(1'b1, n);
    chk(n, 12);
    apb(1'b1, 16'h7fa5, 32'hd0, 4'h1);
    for (k = 0; k < 40 && SECOND_IRQ !== 1'b1; k++) @(posedge CLOCK);
    chk(SECOND_IRQ, 1);
    apb(1'b1, 16'h7fb7, 32'h24, 4'h1);
    repeat (3) @(posedge CLOCK);
    #1;
    last = SECOND_TOGGLE_OUT;
    k = 0;
    repeat (60) begin
      @(posedge CLOCK);
      #1;
      if (SECOND_TOGGLE_OUT !== last) k++;
    end
    chk(k, 0);
    apb(1'b1, 16'h7fa5, 32'h00, 4'h1);
    repeat (3) @(posedge CLOCK);
    chk(SECOND_TOGGLE_OUT, 1);
    $display("Second timer test done");
  endtask
  initial begin
    repeat (12) @(posedge CLOCK);
    RESET <= 1'b0;
    test_regs();
    test_first();
    test_second();
    give_verdict();
  end
endmodule // dual_match_timer_prescaled_tb
